// File: hdl/ffpe_flash_ctrl.sv
// Command decoder and program/erase sequencer of a serial NOR flash.
// Assumes link pins asynchronous to clk and an array outside that applies requests.
`timescale 1ns/1ps
`include "ffpe_defines.svh"

// Overview of operation
// - Quad program: opcode, address, 1-256 data bytes.
// - Quad program needs quad enable and latch.
// - Program into a protected page is ignored.
// - Program starts only on clean select release.
// - Busy bit is one while operation runs.
// - Excess data wraps within page; last wins.
// - Unwritten page bytes stay unchanged.
// - Program only clears bits; erase sets ones.
// - Sectors 4K; blocks 32K or 64K.
// - Sector erase: opcode, address, clears latch.
// - Block erase 32K or 64K, clears latch.
// - Erase starts only on clean select release.
// - Whole erase: opcode only, needs latch.
// - Whole erase refused if protected; flags errors.
// - Latch set command; latch clear at reset.
// - Latch required before every write command.
// - Latch clears when a write completes.
// - Latch clear command blocks writes.
// - Status read works even while busy.
// - Status write sets protect, disable, quad bits.
// - Function read shifts function register out.
// - Function write only sets one-time bits.
// - Opcode two nibbles in four-line, else eight bits.
// - Nibbles sampled on rising clock, MSB on line three.
module ffpe_flash_ctrl
  import ffpe_pkg::*;
#(
  parameter int unsigned PROG_CYC = `FFPE_PROG_US * `FFPE_CLK_MHZ,
  parameter int unsigned SECTOR_CYC = `FFPE_SECTOR_MS * `FFPE_US_PER_MS * `FFPE_CLK_MHZ,
  parameter int unsigned SMALL_CYC = `FFPE_SMALL_BLK_MS * `FFPE_US_PER_MS * `FFPE_CLK_MHZ,
  parameter int unsigned LARGE_CYC = `FFPE_LARGE_BLK_MS * `FFPE_US_PER_MS * `FFPE_CLK_MHZ,
  parameter int unsigned WHOLE_CYC = `FFPE_WHOLE_MS * `FFPE_US_PER_MS * `FFPE_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link pins
  input wire ffpe_link_t link_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Mode
  input wire logic four_line_command_mode,
  // Register state
  output logic [7:0] status_o,
  output logic [7:0] func_o,
  output logic erase_err,
  output logic guarded_erase_flag,
  // Array side
  output ffpe_arr_t arr_o
);
  localparam int unsigned REG_CYC = `FFPE_REG_US * `FFPE_CLK_MHZ;

  logic sel, sck_rise, sck_fall, cs_rise, cs_fall;
  logic [3:0] io_s;
  logic buf_we, buf_clr, buf_mark;
  logic [7:0] buf_rdata;

  ffpe_link_rx u_rx (
    .clk(clk), .nrst(nrst), .link(link_in), .sel(sel), .sck_rise(sck_rise),
    .sck_fall(sck_fall), .cs_rise(cs_rise), .cs_fall(cs_fall), .io(io_s)
  );

  // Link side state.
  ffpe_phase_t phase_r, phase_nxt;
  ffpe_cmd_t cmd_r, cmd_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, regv_r, regv_nxt;
  logic [2:0] bit_r, bit_nxt, txb_r, txb_nxt;
  logic [1:0] abyte_r, abyte_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic wide_r, wide_nxt, bad_r, bad_nxt, got_r, got_nxt;
  logic [3:0] io_out_r, io_out_nxt, io_oe_r, io_oe_nxt;

  // Sequencer and register state.
  ffpe_op_t seq_r, seq_nxt;
  ffpe_kind_t kind_r, kind_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [8:0] pidx_r, pidx_nxt;
  logic [23:0] xaddr_r, xaddr_nxt;
  logic wel_r, wel_nxt, qe_r, qe_nxt, swd_r, swd_nxt, busy_r, busy_nxt;
  logic [3:0] bp_r, bp_nxt, irl_r, irl_nxt;
  logic rst_dis_r, rst_dis_nxt, eerr_r, eerr_nxt, perr_r, perr_nxt;
  ffpe_arr_t arr_r, arr_nxt;

  logic [2:0] bit_sum;
  logic byte_done, prot, ok_end, may_write;
  logic [7:0] rx_byte, cur, status_w, func_w;
  ffpe_cmd_t c;

  assign status_w = {swd_r, qe_r, bp_r, wel_r, busy_r};
  assign func_w = {irl_r, 3'h0, rst_dis_r};

  always_comb begin
    bit_sum = bit_r + (wide_r ? 3'd4 : 3'd1);
    byte_done = sck_rise && bit_sum == 3'd0;
    rx_byte = wide_r ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
    prot = prot_hit(addr_r, bp_r);
    ok_end = !bad_r && bit_r == 3'd0;
    may_write = ok_end && wel_r && seq_r == OP_IDLE;
  end

  // Link side: shift in, decode phases, shift out register reads.
  always_comb begin
    phase_nxt = phase_r;
    cmd_nxt = cmd_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    regv_nxt = regv_r;
    bit_nxt = bit_r;
    txb_nxt = txb_r;
    abyte_nxt = abyte_r;
    addr_nxt = addr_r;
    wide_nxt = wide_r;
    bad_nxt = bad_r;
    got_nxt = got_r;
    io_out_nxt = io_out_r;
    io_oe_nxt = io_oe_r;
    buf_we = 1'b0;
    c = decode_op(rx_byte);
    cur = (txb_r == 3'd0) ? ((cmd_r == C_RD_ST) ? status_w : func_w) : tx_r;
    if (!sel) begin
      phase_nxt = PH_OPC;
      bit_nxt = 3'd0;
      txb_nxt = 3'd0;
      abyte_nxt = 2'd0;
      bad_nxt = 1'b0;
      got_nxt = 1'b0;
      wide_nxt = four_line_command_mode;
      io_oe_nxt = 4'h0;
    end else begin
      if (sck_rise) begin
        sh_nxt = rx_byte;
        bit_nxt = bit_sum;
      end
      if (byte_done) begin
        case (phase_r)
          PH_OPC: begin
            cmd_nxt = c;
            case (c)
              C_PROG: begin
                phase_nxt = PH_ADDR;
                wide_nxt = 1'b1;
              end
              C_ERASE_S, C_ERASE_SB, C_ERASE_LB: phase_nxt = PH_ADDR;
              C_RD_ST, C_RD_FN: phase_nxt = PH_READ;
              C_WR_ST, C_WR_FN: phase_nxt = PH_DATA;
              C_NONE: begin
                phase_nxt = PH_END;
                bad_nxt = 1'b1;
              end
              default: phase_nxt = PH_END;
            endcase
          end
          PH_ADDR: begin
            addr_nxt = {addr_r[15:0], rx_byte};
            abyte_nxt = abyte_r + 2'd1;
            if (abyte_r == 2'd2) phase_nxt = (cmd_r == C_PROG) ? PH_DATA : PH_END;
          end
          PH_DATA: begin
            got_nxt = 1'b1;
            if (cmd_r == C_PROG) begin
              buf_we = seq_r == OP_IDLE;
              addr_nxt[7:0] = addr_r[7:0] + 8'd1;
            end else begin
              regv_nxt = rx_byte;
              phase_nxt = PH_END;
            end
          end
          PH_END: bad_nxt = 1'b1;
          default: ;
        endcase
      end
      if (phase_r == PH_READ && sck_fall) begin
        io_out_nxt = wide_r ? cur[7:4] : {2'b00, cur[7], 1'b0};
        io_oe_nxt = wide_r ? 4'hf : 4'h2;
        tx_nxt = wide_r ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
        txb_nxt = txb_r + (wide_r ? 3'd4 : 3'd1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= PH_OPC;
      cmd_r <= C_NONE;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      regv_r <= 8'h00;
      bit_r <= 3'd0;
      txb_r <= 3'd0;
      abyte_r <= 2'd0;
      addr_r <= 24'h00_0000;
      wide_r <= 1'b0;
      bad_r <= 1'b0;
      got_r <= 1'b0;
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
      cmd_r <= cmd_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      regv_r <= regv_nxt;
      bit_r <= bit_nxt;
      txb_r <= txb_nxt;
      abyte_r <= abyte_nxt;
      addr_r <= addr_nxt;
      wide_r <= wide_nxt;
      bad_r <= bad_nxt;
      got_r <= got_nxt;
      io_out_r <= io_out_nxt;
      io_oe_r <= io_oe_nxt;
    end
  end

  ffpe_page_buf u_buf (
    .clk(clk), .nrst(nrst), .clr(buf_clr), .we(buf_we), .widx(addr_r[7:0]),
    .wdata(rx_byte), .ridx(pidx_r[7:0]), .rdata(buf_rdata), .rmark(buf_mark)
  );

  // Sequencer: accepts commands on select release and times the array work.
  always_comb begin
    seq_nxt = seq_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    pidx_nxt = pidx_r;
    xaddr_nxt = xaddr_r;
    wel_nxt = wel_r;
    qe_nxt = qe_r;
    swd_nxt = swd_r;
    bp_nxt = bp_r;
    irl_nxt = irl_r;
    rst_dis_nxt = rst_dis_r;
    eerr_nxt = eerr_r;
    perr_nxt = perr_r;
    arr_nxt = '0;
    buf_clr = cs_fall && seq_r == OP_IDLE;
    if (cs_rise && ok_end && phase_r == PH_END) begin
      if (cmd_r == C_SET) wel_nxt = 1'b1;
      if (cmd_r == C_CLR) wel_nxt = 1'b0;
    end
    case (seq_r)
      OP_IDLE: begin
        if (cs_rise && may_write) begin
          case (cmd_r)
            C_PROG: if (phase_r == PH_DATA && got_r && qe_r && !prot) begin
              seq_nxt = OP_LOAD;
              kind_nxt = K_PROG;
              pidx_nxt = 9'd0;
              xaddr_nxt = addr_r;
            end
            C_ERASE_S, C_ERASE_SB, C_ERASE_LB: if (phase_r == PH_END && !prot) begin
              seq_nxt = OP_WAIT;
              kind_nxt = K_ERASE;
              eerr_nxt = 1'b0;
              perr_nxt = 1'b0;
              arr_nxt.erase = 1'b1;
              arr_nxt.addr = addr_r;
              case (cmd_r)
                C_ERASE_S: begin
                  arr_nxt.size = ER_SECTOR;
                  cnt_nxt = SECTOR_CYC;
                end
                C_ERASE_SB: begin
                  arr_nxt.size = ER_SMALL;
                  cnt_nxt = SMALL_CYC;
                end
                default: begin
                  arr_nxt.size = ER_LARGE;
                  cnt_nxt = LARGE_CYC;
                end
              endcase
            end
            C_ERASE_ALL: if (phase_r == PH_END) begin
              if (bp_r != 4'd0) begin
                eerr_nxt = 1'b1;
                perr_nxt = 1'b1;
              end else begin
                seq_nxt = OP_WAIT;
                kind_nxt = K_ERASE;
                eerr_nxt = 1'b0;
                perr_nxt = 1'b0;
                arr_nxt.erase = 1'b1;
                arr_nxt.size = ER_WHOLE;
                cnt_nxt = WHOLE_CYC;
              end
            end
            C_WR_ST, C_WR_FN: if (phase_r == PH_END && got_r) begin
              seq_nxt = OP_WAIT;
              kind_nxt = (cmd_r == C_WR_ST) ? K_SREG : K_FREG;
              cnt_nxt = REG_CYC;
            end
            default: ;
          endcase
        end
      end
      OP_LOAD: begin
        // Only marked bytes go out, so the rest of the page is left alone.
        if (buf_mark) begin
          arr_nxt.prog = 1'b1;
          arr_nxt.addr = {xaddr_r[23:8], pidx_r[7:0]};
          arr_nxt.data = buf_rdata;
        end
        pidx_nxt = pidx_r + 9'd1;
        if (pidx_r[7:0] == 8'hff) begin
          seq_nxt = OP_WAIT;
          cnt_nxt = PROG_CYC;
        end
      end
      OP_WAIT: begin
        if (cnt_r <= 32'd1) seq_nxt = OP_DONE;
        else cnt_nxt = cnt_r - 32'd1;
      end
      OP_DONE: begin
        wel_nxt = 1'b0;
        if (kind_r == K_SREG) begin
          bp_nxt = regv_r[`FFPE_SR_BP_HI:`FFPE_SR_BP_LO];
          qe_nxt = regv_r[`FFPE_SR_QE];
          swd_nxt = regv_r[`FFPE_SR_SWD];
        end
        if (kind_r == K_FREG) begin
          irl_nxt = irl_r | regv_r[`FFPE_FR_IRL_HI:`FFPE_FR_IRL_LO];
          rst_dis_nxt = rst_dis_r | regv_r[`FFPE_FR_RST_DIS];
        end
        seq_nxt = OP_IDLE;
      end
      default: seq_nxt = OP_IDLE;
    endcase
    busy_nxt = seq_nxt != OP_IDLE;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_r <= OP_IDLE;
      kind_r <= K_PROG;
      cnt_r <= 32'h0000_0000;
      pidx_r <= 9'd0;
      xaddr_r <= 24'h00_0000;
      wel_r <= 1'b0;
      qe_r <= 1'b0;
      swd_r <= 1'b0;
      busy_r <= 1'b0;
      bp_r <= 4'h0;
      irl_r <= 4'h0;
      rst_dis_r <= 1'b0;
      eerr_r <= 1'b0;
      perr_r <= 1'b0;
      arr_r <= '0;
    end else begin
      seq_r <= seq_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      pidx_r <= pidx_nxt;
      xaddr_r <= xaddr_nxt;
      wel_r <= wel_nxt;
      qe_r <= qe_nxt;
      swd_r <= swd_nxt;
      busy_r <= busy_nxt;
      bp_r <= bp_nxt;
      irl_r <= irl_nxt;
      rst_dis_r <= rst_dis_nxt;
      eerr_r <= eerr_nxt;
      perr_r <= perr_nxt;
      arr_r <= arr_nxt;
    end
  end

  assign io_out = io_out_r;
  assign io_oe = io_oe_r;
  assign status_o = status_w;
  assign func_o = func_w;
  assign erase_err = eerr_r;
  assign guarded_erase_flag = perr_r;
  assign arr_o = arr_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_busy_bit: assert property (cs_rise && may_write && phase_r == PH_END && !prot &&
    cmd_r inside {C_ERASE_S, C_ERASE_SB, C_ERASE_LB} |=> status_o[`FFPE_SR_BUSY] && arr_o.erase)
    else $error("accepted erase did not raise busy");
  chk_prog_start: assert property (cs_rise && may_write && cmd_r == C_PROG &&
    phase_r == PH_DATA && got_r && qe_r && !prot |=> seq_r == OP_LOAD)
    else $error("valid program not started");
  chk_prot_skip: assert property (cs_rise && seq_r == OP_IDLE && prot &&
    cmd_r inside {C_PROG, C_ERASE_S, C_ERASE_SB, C_ERASE_LB} |=> seq_r == OP_IDLE)
    else $error("protected target was written");
  chk_partial_byte: assert property (cs_rise && seq_r == OP_IDLE && bit_r != 3'd0
    |=> seq_r == OP_IDLE && $stable(status_o))
    else $error("command with partial byte acted");
  chk_whole_err: assert property (cs_rise && may_write && cmd_r == C_ERASE_ALL &&
    phase_r == PH_END && bp_r != 4'd0 |=> erase_err && guarded_erase_flag && seq_r == OP_IDLE)
    else $error("guarded whole erase not refused");
  chk_latch_set: assert property (cs_rise && ok_end && cmd_r == C_SET &&
    phase_r == PH_END && seq_r != OP_DONE |=> status_o[`FFPE_SR_LATCH])
    else $error("latch set command had no effect");
  chk_latch_done: assert property (seq_r == OP_DONE |=> !status_o[`FFPE_SR_LATCH])
    else $error("latch not cleared at completion");
  chk_busy_reject: assert property (seq_r == OP_WAIT && cs_rise
    |=> seq_r inside {OP_WAIT, OP_DONE} && $stable(cnt_r) == 1'b0 || seq_r == OP_DONE)
    else $error("command accepted while busy");
  chk_otp_bits: assert property (##1 (func_o & $past(func_o)) == $past(func_o))
    else $error("one-time bit was cleared");
  chk_read_lanes: assert property (phase_r == PH_READ && sck_fall
    |=> io_oe == ($past(wide_r) ? 4'hf : 4'h2))
    else $error("read data on wrong lanes");
endmodule : ffpe_flash_ctrl

// File: pkg/ffpe_defines.svh
// Opcodes, register bit positions, array geometry and timing figures.
// Included by the package and by every design file.
`ifndef FFPE_DEFINES_SVH
`define FFPE_DEFINES_SVH
`define FFPE_OP_QUAD_PROG_A 8'h32
`define FFPE_OP_QUAD_PROG_B 8'h38
`define FFPE_OP_SECTOR_ERASE_A 8'hd7
`define FFPE_OP_SECTOR_ERASE_B 8'h20
`define FFPE_OP_SMALL_BLOCK_ERASE 8'h52
`define FFPE_OP_LARGE_BLOCK_ERASE 8'hd8
`define FFPE_OP_WHOLE_ERASE_A 8'hc7
`define FFPE_OP_WHOLE_ERASE_B 8'h60
`define FFPE_OP_LATCH_SET 8'h06
`define FFPE_OP_LATCH_CLEAR 8'h04
`define FFPE_OP_STATUS_READ 8'h05
`define FFPE_OP_STATUS_WRITE 8'h01
`define FFPE_OP_FUNC_READ 8'h48
`define FFPE_OP_FUNC_WRITE 8'h42
`define FFPE_SR_BUSY 0
`define FFPE_SR_LATCH 1
`define FFPE_SR_BP_LO 2
`define FFPE_SR_BP_HI 5
`define FFPE_SR_QE 6
`define FFPE_SR_SWD 7
`define FFPE_FR_RST_DIS 0
`define FFPE_FR_IRL_LO 4
`define FFPE_FR_IRL_HI 7
`define FFPE_PAGE_BYTES 256
`define FFPE_BLK_HI 20
`define FFPE_BLK_LO 16
`define FFPE_NUM_BLOCKS 6'd32
`define FFPE_BP_ALL 4'd6
`define FFPE_CLK_MHZ 100
`define FFPE_US_PER_MS 1000
`define FFPE_PROG_US 800
`define FFPE_REG_US 2
`define FFPE_SECTOR_MS 70
`define FFPE_SMALL_BLK_MS 100
`define FFPE_LARGE_BLK_MS 150
`define FFPE_WHOLE_MS 5000
`endif

// File: pkg/ffpe_pkg.sv
// Types and shared helper functions of the flash command sequencer.
// Needs ffpe_defines.svh on the include path.
`include "ffpe_defines.svh"
package ffpe_pkg;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic [3:0] io;
  } ffpe_link_t;
  typedef enum logic [1:0] {ER_SECTOR, ER_SMALL, ER_LARGE, ER_WHOLE} ffpe_esize_t;
  typedef struct packed {
    logic prog;
    logic erase;
    ffpe_esize_t size;
    logic [23:0] addr;
    logic [7:0] data;
  } ffpe_arr_t;
  typedef enum logic [4:0] {
    PH_OPC = 5'b00001, PH_ADDR = 5'b00010, PH_DATA = 5'b00100,
    PH_END = 5'b01000, PH_READ = 5'b10000
  } ffpe_phase_t;
  typedef enum logic [3:0] {
    OP_IDLE = 4'b0001, OP_LOAD = 4'b0010, OP_WAIT = 4'b0100, OP_DONE = 4'b1000
  } ffpe_op_t;
  typedef enum logic [1:0] {K_PROG, K_ERASE, K_SREG, K_FREG} ffpe_kind_t;
  typedef enum logic [3:0] {
    C_NONE, C_PROG, C_ERASE_S, C_ERASE_SB, C_ERASE_LB, C_ERASE_ALL,
    C_SET, C_CLR, C_RD_ST, C_WR_ST, C_RD_FN, C_WR_FN
  } ffpe_cmd_t;

  function automatic ffpe_cmd_t decode_op(input logic [7:0] op);
    case (op)
      `FFPE_OP_QUAD_PROG_A, `FFPE_OP_QUAD_PROG_B: decode_op = C_PROG;
      `FFPE_OP_SECTOR_ERASE_A, `FFPE_OP_SECTOR_ERASE_B: decode_op = C_ERASE_S;
      `FFPE_OP_SMALL_BLOCK_ERASE: decode_op = C_ERASE_SB;
      `FFPE_OP_LARGE_BLOCK_ERASE: decode_op = C_ERASE_LB;
      `FFPE_OP_WHOLE_ERASE_A, `FFPE_OP_WHOLE_ERASE_B: decode_op = C_ERASE_ALL;
      `FFPE_OP_LATCH_SET: decode_op = C_SET;
      `FFPE_OP_LATCH_CLEAR: decode_op = C_CLR;
      `FFPE_OP_STATUS_READ: decode_op = C_RD_ST;
      `FFPE_OP_STATUS_WRITE: decode_op = C_WR_ST;
      `FFPE_OP_FUNC_READ: decode_op = C_RD_FN;
      `FFPE_OP_FUNC_WRITE: decode_op = C_WR_FN;
      default: decode_op = C_NONE;
    endcase
  endfunction : decode_op

  // Protect bits n = 1..5 guard the top 2^(n-1) 64 Kbyte blocks; 6 and up guard all.
  function automatic logic prot_hit(input logic [23:0] a, input logic [3:0] bp);
    if (bp == 4'd0) prot_hit = 1'b0;
    else if (bp >= `FFPE_BP_ALL) prot_hit = 1'b1;
    else prot_hit = {1'b0, a[`FFPE_BLK_HI:`FFPE_BLK_LO]} >=
                    (`FFPE_NUM_BLOCKS - (6'd1 << (bp - 4'd1)));
  endfunction : prot_hit
endpackage : ffpe_pkg

// File: hdl/ffpe_link_rx.sv
// Two-stage synchroniser of the serial link pins with edge detection.
// Assumes the pins are asynchronous to clk and sck is far slower than clk.
`timescale 1ns/1ps
`include "ffpe_defines.svh"
module ffpe_link_rx
  import ffpe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Raw pins
  input wire ffpe_link_t link,
  // Sampled view
  output logic sel,
  output logic sck_rise,
  output logic sck_fall,
  output logic cs_rise,
  output logic cs_fall,
  output logic [3:0] io
);
  ffpe_link_t s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;

  always_comb begin
    s1_nxt = link;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '{sck: 1'b0, cs_n: 1'b1, io: 4'h0};
      s2_r <= '{sck: 1'b0, cs_n: 1'b1, io: 4'h0};
      s3_r <= '{sck: 1'b0, cs_n: 1'b1, io: 4'h0};
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // Data is taken with the same delay as the clock, so it is the level seen at the rising edge.
  assign sel = ~s2_r.cs_n;
  assign sck_rise = sel & s2_r.sck & ~s3_r.sck;
  assign sck_fall = sel & ~s2_r.sck & s3_r.sck;
  assign cs_rise = s2_r.cs_n & ~s3_r.cs_n;
  assign cs_fall = ~s2_r.cs_n & s3_r.cs_n;
  assign io = s2_r.io;
endmodule : ffpe_link_rx

// File: hdl/ffpe_page_buf.sv
// Page buffer of the program command with a per-byte written mark.
// Assumes writes and the drain walk never overlap.
`timescale 1ns/1ps
`include "ffpe_defines.svh"
module ffpe_page_buf
  import ffpe_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  input wire logic clr,
  input wire logic we,
  input wire logic [7:0] widx,
  input wire logic [7:0] wdata,
  // Drain side
  input wire logic [7:0] ridx,
  output logic [7:0] rdata,
  output logic rmark
);
  logic [7:0] mem_r [`FFPE_PAGE_BYTES];
  logic [7:0] mem_nxt [`FFPE_PAGE_BYTES];
  logic [`FFPE_PAGE_BYTES-1:0] mark_r, mark_nxt;

  // A later byte at the same index replaces the earlier one, so the last page of data wins.
  always_comb begin
    mem_nxt = mem_r;
    mark_nxt = mark_r;
    if (clr) mark_nxt = '0;
    if (we) begin
      mem_nxt[widx] = wdata;
      mark_nxt[widx] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    mem_r <= mem_nxt;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mark_r <= '0;
    else mark_r <= mark_nxt;
  end

  assign rdata = mem_r[ridx];
  assign rmark = mark_r[ridx];

  chk_buf_write: assert property (@(posedge clk) disable iff (!nrst)
    we |=> mark_r[$past(widx)] && mem_r[$past(widx)] == $past(wdata))
    else $error("page buffer lost a written byte");
endmodule : ffpe_page_buf

// File: test/ffpe_host_model.sv
// Host link model: select, serial clock and data lines of the controller.
// Assumes the bench resolves the data lines from the controller's enables.
`timescale 1ns/1ps
module ffpe_host_model
  import ffpe_pkg::*;
(
  // Resolved data lines
  input wire logic [3:0] io_wire,
  // Host pins
  output ffpe_link_t link
);
  initial link = 6'h10;
  task automatic sel_on();
    link.cs_n <= 1'b0;
    #62.5;
  endtask : sel_on
  // The clock rests low and released lines toggle once at each select release.
  task automatic sel_off();
    #62.5;
    link.cs_n <= 1'b1;
    link.io <= ~link.io;
    #150;
  endtask : sel_off
  // Moves one byte, or half of it when cut is set.
  task automatic xfer(input logic [7:0] b, input logic q, input logic rd, input logic cut,
                      output logic [7:0] r);
    int n;
    n = (q ? 2 : 8) >> cut;
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (rd) link.io <= ~link.io;
      else if (q) link.io <= b[7-4*i -: 4];
      else link.io <= {~link.io[3:1], b[7-i]};
      #62.5;
      link.sck <= 1'b1;
      r = q ? {r[3:0], io_wire} : {r[6:0], io_wire[1]};
      #62.5;
      link.sck <= 1'b0;
    end
  endtask : xfer
endmodule : ffpe_host_model

// File: test/ffpe_flash_ctrl_tb_top.sv
// Self-checking bench of the flash command sequencer.
// Assumes the host model drives the link and shortened operation times.
`timescale 1ns/1ps
module ffpe_flash_ctrl_tb_top;
  import ffpe_pkg::*;
  localparam int unsigned CYC = 50;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic quad = 1'b0;
  ffpe_link_t hl;
  ffpe_link_t link_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [7:0] status_o;
  logic [7:0] func_o;
  logic erase_err;
  logic guarded_erase_flag;
  ffpe_arr_t arr_o;
  ffpe_arr_t last_e;
  int error_cnt = 0;
  int check_count = 0;
  int pcnt = 0;
  int ecnt = 0;
  logic [7:0] mem [256];
  logic [7:0] r;
  logic [7:0] ops [6] = '{8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  logic [1:0] szs [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  always #5 clk = ~clk;
  assign link_in = {hl.sck, hl.cs_n, (io_oe & io_out) | (~io_oe & hl.io)};
  ffpe_host_model i_host (.io_wire(link_in.io), .link(hl));
  ffpe_flash_ctrl #(.PROG_CYC(CYC), .SECTOR_CYC(CYC), .SMALL_CYC(CYC), .LARGE_CYC(CYC),
    .WHOLE_CYC(CYC)) i_dut (.clk(clk), .nrst(nrst), .link_in(link_in), .io_out(io_out),
    .io_oe(io_oe), .four_line_command_mode(quad), .status_o(status_o), .func_o(func_o),
    .erase_err(erase_err), .guarded_erase_flag(guarded_erase_flag), .arr_o(arr_o));
  always @(posedge clk) begin
    if (arr_o.prog === 1'b1) begin
      if (arr_o.addr[23:8] === 16'h1201) mem[arr_o.addr[7:0]] = arr_o.data;
      pcnt++;
    end
    if (arr_o.erase === 1'b1) begin
      last_e = arr_o;
      ecnt++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic wait_idle();
    int k;
    k = 0;
    while (status_o[0] !== 1'b0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk(k < 5000, 1, "busy stuck");
  endtask : wait_idle
  // Sends one command frame; program address and data always use four lines.
  task automatic cmd(input logic [7:0] op, input int na, input int nd, input logic w);
    logic aq;
    aq = quad | (op == 8'h32) | (op == 8'h38);
    i_host.sel_on();
    i_host.xfer(op, quad, 1'b0, 1'b0, r);
    for (int i = 0; i < na; i++) i_host.xfer(8'h12 >> (4 * i), aq, 1'b0, 1'b0, r);
    for (int k = 0; k < nd; k++) begin
      i_host.xfer(8'h5a ^ k[7:0] ^ {k[8], 7'h00}, aq, 1'b0, 1'b0, r);
    end
    i_host.sel_off();
    if (w) wait_idle();
  endtask : cmd
  task automatic rd_reg(input logic [7:0] op);
    i_host.sel_on();
    i_host.xfer(op, quad, 1'b0, 1'b0, r);
    i_host.xfer(8'h00, quad, 1'b1, 1'b0, r);
    i_host.sel_off();
  endtask : rd_reg
  task automatic wr_reg(input logic [7:0] op, input logic [7:0] d, input logic w);
    logic [7:0] x;
    cmd(8'h06, 0, 0, 1'b1);
    i_host.sel_on();
    i_host.xfer(op, quad, 1'b0, 1'b0, x);
    i_host.xfer(d, quad, 1'b0, 1'b0, x);
    i_host.sel_off();
    if (w) wait_idle();
  endtask : wr_reg
  initial begin
    #900_000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    chk({status_o, func_o, erase_err, guarded_erase_flag}, 0, "reset state");
    cmd(8'h32, 3, 4, 1'b1);
    chk(pcnt, 0, "program without latch");
    cmd(8'h06, 0, 0, 1'b1);
    cmd(8'h32, 3, 4, 1'b1);
    chk(pcnt, 0, "program without quad enable");
    wr_reg(8'h01, 8'h40, 1'b0);
    rd_reg(8'h05);
    chk(r, 8'h03, "status read while busy");
    wait_idle();
    chk(status_o, 8'h40, "status write");
    for (int t = 0; t < 2; t++) begin
      mem = '{default: 8'hxx};
      pcnt = 0;
      cmd(8'h06, 0, 0, 1'b1);
      cmd(t ? 8'h38 : 8'h32, 3, t ? 1 : 258, 1'b1);
      chk(pcnt, t ? 1 : 256, "program byte count");
      for (int k = t ? 0 : 2; k < (t ? 1 : 258); k++)
        chk(mem[k[7:0]], 8'h5a ^ k[7:0] ^ {k[8], 7'h00}, "program data");
      chk(status_o, 8'h40, "latch after program");
    end
    ecnt = 0;
    wr_reg(8'h01, 8'hd4, 1'b1);
    chk(status_o, 8'hd4, "status write all bits");
    pcnt = 0;
    cmd(8'h06, 0, 0, 1'b1);
    cmd(8'h32, 3, 1, 1'b1);
    chk(pcnt, 0, "program into protected page");
    cmd(8'h06, 0, 0, 1'b1);
    cmd(8'hc7, 0, 0, 1'b1);
    chk({erase_err, guarded_erase_flag, ecnt[3:0]}, 6'h30, "guarded whole erase");
    wr_reg(8'h01, 8'h40, 1'b1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) quad <= i[0];
      ecnt = 0;
      cmd(8'h06, 0, 0, 1'b1);
      cmd(ops[i], szs[i] == 2'h3 ? 0 : 3, 0, 1'b1);
      chk({ecnt[3:0], last_e.size}, {4'h1, szs[i]}, "erase kind");
      chk({erase_err, status_o}, 9'h040, "latch after erase");
    end
    @(posedge clk) quad <= 1'b0;
    ecnt = 0;
    cmd(8'h06, 0, 0, 1'b1);
    cmd(8'h04, 0, 0, 1'b1);
    cmd(8'hd7, 3, 0, 1'b1);
    chk(ecnt, 0, "erase after latch clear");
    cmd(8'h06, 0, 0, 1'b1);
    i_host.sel_on();
    i_host.xfer(8'hd7, quad, 1'b0, 1'b0, r);
    i_host.xfer(8'h12, quad, 1'b0, 1'b1, r);
    i_host.sel_off();
    chk({ecnt[3:0], status_o}, 12'h042, "erase with broken frame");
    @(posedge clk) quad <= 1'b1;
    wr_reg(8'h42, 8'hf1, 1'b0);
    cmd(8'hd7, 3, 0, 1'b1);
    chk({ecnt[3:0], func_o}, 12'h0f1, "erase while busy and function write");
    wr_reg(8'h42, 8'h00, 1'b1);
    rd_reg(8'h48);
    chk({r, func_o}, 16'hf1f1, "one-time bits and function read");
    end_sim();
  end
endmodule : ffpe_flash_ctrl_tb_top
